// ---- dac_global_request_control_test.sv ----
// Self-checking bench for dgr_top with the converter model.
// Assumes dgr_props is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module dac_global_request_control_test;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [9:0] reg_addr = 10'h0;
   logic reg_wr = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_rd = 1'b0;
   logic [7:0] conv_mode = 8'h0;
   logic [3:0] xfer_busy = 4'h0;
   wire [31:0] reg_rdata;
   wire [3:0] cfg_done, conv_reset_n, conv_pulse, cfg_req;
   wire [3:0] conv_reset_n2, conv_pulse2;
   int miscompares = 0;
   int num_checks = 0;
   int n;
   dgr_top #(.NUM_CONV(4)) uut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .conv_mode(conv_mode), .xfer_busy(xfer_busy), .cfg_done(cfg_done),
      .conv_reset_n(conv_reset_n), .conv_pulse(conv_pulse), .cfg_req(cfg_req));
   dgr_conv_model far (.clk_sys(clk_sys), .conv_reset_n(conv_reset_n), .cfg_req(cfg_req),
      .cfg_done(cfg_done));
   // Eight-channel build beside it; its slots 0 and 1 mirror uut
   dgr_top #(.NUM_CONV(2)) uut2 (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(),
      .conv_mode(conv_mode), .xfer_busy(xfer_busy), .cfg_done(cfg_done),
      .conv_reset_n(conv_reset_n2), .conv_pulse(conv_pulse2), .cfg_req());
   // 50 ns period
   initial forever #25 clk_sys = ~clk_sys;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Inputs always move 1 ns after the edge
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      step(1);
      reg_wr = 1'b0;
   endtask
   // Extra cycle before sampling, so strobes never toggle in one step
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      step(1);
      reg_rd = 1'b0;
      step(1);
      check(reg_rdata, exp);
   endtask
   task automatic t_idle();
      wr(10'h15c, 32'h000f000f);
      rd_chk(10'h158, 32'h0);
      rd_chk(10'h158, 32'h0);
      rd_chk(10'h15c, 32'h0);
      rd_chk(10'h160, 32'h0);
      $display("test idle done");
   endtask
   task automatic t_reset_req();
      wr(10'h158, 32'h000f0000);
      step(1);
      check({28'h0, conv_reset_n}, 32'h0);
      check({28'h0, conv_reset_n2}, 32'hc);
      n = 0;
      while (conv_reset_n !== 4'hf && n < 100) begin
         step(1);
         n++;
      end
      check(n, 32'd20);
      check({28'h0, cfg_req}, 32'hf);
      rd_chk(10'h15c, 32'hf);
      step(8);
      rd_chk(10'h158, 32'h0);
      rd_chk(10'h15c, 32'h0);
      $display("test reset request done");
   endtask
   task automatic t_pulse();
      rd_chk(10'h15c, 32'h0);
      wr(10'h158, 32'h5);
      step(1);
      check({28'h0, conv_pulse}, 32'h5);
      check({28'h0, conv_pulse2}, 32'h1);
      step(1);
      check({28'h0, conv_pulse}, 32'h0);
      rd_chk(10'h158, 32'h0);
      $display("test pulse done");
   endtask
   // Slots alternate immediate and sequencer modes
   task automatic t_mode();
      conv_mode = 8'h99;
      step(1);
      wr(10'h158, 32'hf);
      step(1);
      check({28'h0, conv_pulse}, 32'h0);
      rd_chk(10'h158, 32'h0);
      conv_mode = 8'h0;
      step(2);
      $display("test mode done");
   endtask
   task automatic t_pending();
      xfer_busy = 4'h2;
      step(1);
      wr(10'h158, 32'h2);
      step(3);
      check({28'h0, conv_pulse}, 32'h0);
      rd_chk(10'h158, 32'h2);
      xfer_busy = 4'h0;
      n = 0;
      while (conv_pulse !== 4'h2 && n < 20) begin
         step(1);
         n++;
      end
      check({28'h0, conv_pulse}, 32'h2);
      step(2);
      rd_chk(10'h158, 32'h0);
      $display("test pending done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Reset for 12 cycles, then the tests in turn
   initial begin
      step(12);
      arst_n = 1'b1;
      step(1);
      t_idle();
      t_reset_req();
      t_pulse();
      t_mode();
      t_pending();
      end_sim();
   end
   // Tests need under 100 cycles; 2000 means a hang
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
endmodule
`default_nettype wire

// ---- dgr_consts.vh ----
// Constants for the converter global request control block.
// Included by bare name; holds definitions only.
`ifndef DGR_CONSTS_VH
`define DGR_CONSTS_VH

// Register space
`define DGR_ADDR_W 10
`define DGR_CTRL_OFFSET 10'h158
`define DGR_STAT_OFFSET 10'h15c
`define DGR_CTRL_RESET 32'h00000000

// Field positions inside the control and status words
`define DGR_PULSE_LSB 0
`define DGR_RESET_LSB 16
`define DGR_BUSY_LSB 0
`define DGR_NUM_CONV_MAX 4

// Conversion modes, two bits per converter
`define DGR_MODE_MANUAL_CTL 2'h0
`define DGR_MODE_MANUAL_IMM 2'h1
`define DGR_MODE_SEQUENCER 2'h2

// Clock and reset pulse timing
`define DGR_CLK_MHZ 20
`define DGR_RESET_NS 1000
`define DGR_RESET_CYC ((`DGR_RESET_NS * `DGR_CLK_MHZ + 999) / 1000)

`endif

// ---- dgr_conv_chan.v ----
// Per-converter sequencer: hardware reset phase, auto-configuration
// handshake and single-cycle conversion pulse.
// Assumes the request bits are held in the parent and cleared there
// on the one-cycle clear strobes produced here.
`timescale 1ns/1ps
`default_nettype none
`include "dgr_consts.vh"

module dgr_conv_chan (
   input wire clk_sys,
   input wire arst_n,
   input wire rst_pending,
   input wire pulse_pending,
   input wire xfer_busy,
   input wire cfg_done,
   output reg conv_reset_n,
   output reg conv_pulse,
   output reg cfg_req,
   output reg busy,
   output reg rst_clear,
   output reg pulse_clear
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RESET = 3'h1;
   localparam [2:0] ST_CFG = 3'h2;
   localparam [2:0] ST_PULSE = 3'h3;
   localparam [2:0] ST_WRAP = 3'h4;
   // Full-width cycle count first, then cut to the counter width
   localparam [31:0] RST_CYC_FULL = `DGR_RESET_CYC;
   localparam [7:0] RST_CYC = RST_CYC_FULL[7:0];

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [7:0] cnt_reg;

   // Next-state choice; reset requests outrank pulses
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (rst_pending) begin
               state_next = ST_RESET; // RULE4
            end else if (pulse_pending && !xfer_busy) begin
               state_next = ST_PULSE; // RULE14
            end
         end
         ST_RESET: begin
            if (cnt_reg == RST_CYC - 8'h01) begin
               state_next = ST_CFG; // RULE13
            end
         end
         ST_CFG: begin
            if (cfg_done) begin
               state_next = ST_WRAP; // RULE5
            end
         end
         // One extra cycle lets the parent drop the request bit
         ST_PULSE: state_next = ST_WRAP;
         ST_WRAP: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // State, counter and registered pin drive
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         conv_reset_n <= 1'b1;
         conv_pulse <= 1'b0;
         cfg_req <= 1'b0;
         busy <= 1'b0;
         rst_clear <= 1'b0;
         pulse_clear <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= (state_reg == ST_RESET) ? cnt_reg + 8'h01 : 8'h00;
         conv_reset_n <= (state_next != ST_RESET); // RULE4
         conv_pulse <= (state_next == ST_PULSE); // RULE7
         cfg_req <= (state_next == ST_CFG); // RULE5
         // Busy spans reset, configuration and outside transfers
         busy <= (state_next != ST_IDLE) || xfer_busy; // RULE6 RULE12
         rst_clear <= (state_reg == ST_CFG) && cfg_done; // RULE6
         pulse_clear <= (state_next == ST_PULSE); // RULE1
      end
   end

endmodule
`default_nettype wire

// ---- dgr_conv_model.sv ----
// Far-side converter model: answers auto-configuration requests.
// Assumes cfg_req stays high until cfg_done is seen.
`timescale 1ns/1ps
`default_nettype none
module dgr_conv_model (
   input wire logic clk_sys,
   input wire logic [3:0] conv_reset_n,
   input wire logic [3:0] cfg_req,
   output logic [3:0] cfg_done = 4'h0
);
   logic [3:0] seen_reg = 4'h0;
   logic [3:0] ready_reg = 4'h0;
   // Held in reset, nothing is accepted; answer three cycles after the request
   always @(posedge clk_sys) begin
      seen_reg <= cfg_req & conv_reset_n;
      ready_reg <= seen_reg & cfg_req;
      cfg_done <= ready_reg & cfg_req & ~cfg_done;
   end
endmodule
`default_nettype wire

// ---- dgr_props.sv ----
// Port checker for dgr_top; slot zero stands for all four slots.
// Assumes binding to every dgr_top instance.
`timescale 1ns/1ps
`default_nettype none
module dgr_props #(
   parameter NUM_CONV = 4
) (
   input wire clk_sys,
   input wire arst_n,
   input wire [9:0] reg_addr,
   input wire reg_wr,
   input wire [31:0] reg_wdata,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire [7:0] conv_mode,
   input wire [3:0] xfer_busy,
   input wire [3:0] cfg_done,
   input wire [3:0] conv_reset_n,
   input wire [3:0] conv_pulse,
   input wire [3:0] cfg_req
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Pulses last one cycle and only follow manual controlled mode
   a_pulse_single: assert property ((conv_pulse & $past(conv_pulse)) == 4'h0)
      else $error("pulse wider than one cycle");
   a_pulse_mode: assert property (conv_pulse[0] |-> $past(conv_mode[1:0]) == 2'h0)
      else $error("pulse outside manual controlled mode");
   a_pulse_idle: assert property (cfg_req[0] || !conv_reset_n[0] |-> !conv_pulse[0])
      else $error("pulse while converter busy");
   // Reset request timing: start, fixed width, then configuration
   a_rst_start: assert property (reg_wr && reg_addr == 10'h158 && reg_wdata[16]
      && conv_reset_n[0] && !cfg_req[0] |-> ##2 !conv_reset_n[0])
      else $error("reset pin not driven low");
   a_rst_width: assert property ($fell(conv_reset_n[0])
      |-> ##19 !conv_reset_n[0] ##1 conv_reset_n[0])
      else $error("reset pin width wrong");
   a_cfg_after: assert property ($rose(conv_reset_n[0]) |-> cfg_req[0])
      else $error("no configuration after reset");
   a_cfg_drop: assert property (cfg_req[0] && cfg_done[0] |=> !cfg_req[0])
      else $error("configuration request stuck");
   // Reads: reserved bits and unmapped places give zero
   a_rsvd_zero: assert property ($past(reg_rd) |-> (reg_rdata & 32'hfff0fff0) == 32'h0)
      else $error("reserved bits not zero");
   a_unmapped_zero: assert property (reg_rd && reg_addr != 10'h158 && reg_addr != 10'h15c
      |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind dgr_top dgr_props #(.NUM_CONV(NUM_CONV)) chk (.clk_sys(clk_sys), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .conv_mode(conv_mode), .xfer_busy(xfer_busy),
   .cfg_done(cfg_done), .conv_reset_n(conv_reset_n), .conv_pulse(conv_pulse),
   .cfg_req(cfg_req));
`default_nettype wire

// ---- dgr_top.v ----
// Global converter request control: control register at 0x158,
// busy status at 0x15c, per-converter reset and pulse requests.
// Assumes a simple synchronous register port from the host bridge:
// one-cycle write and read strobes with a byte address; read data
// is returned one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "dgr_consts.vh"

// Operation
// RULE1: Request bits set by software, cleared by hardware
// RULE2: Sticky bits set by event, cleared by one
// RULE3: Reserved bits read zero, writes ignored
// RULE4: Reset request drives converter reset pin low
// RULE5: Auto-configuration follows the reset phase
// RULE6: Reset bit self-clears; busy covers both phases
// RULE7: Manual mode: one pulse, then bit clears
// RULE8: Software checks busy before pulse request
// RULE9: Other modes: pulse request ignored, cleared
// RULE10: Control register at 0x158, resets to zero
// RULE11: Eight-channel build: converters three, four reserved
// RULE12: Busy flags at status bits zero to three
// RULE13: Reset pin held low a fixed time
// RULE14: Pulse requests wait while converter busy
module dgr_top #(
   parameter NUM_CONV = 4
) (
   input wire clk_sys,
   input wire arst_n,
   input wire [9:0] reg_addr,
   input wire reg_wr,
   input wire [31:0] reg_wdata,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [7:0] conv_mode,
   input wire [3:0] xfer_busy,
   input wire [3:0] cfg_done,
   output wire [3:0] conv_reset_n,
   output wire [3:0] conv_pulse,
   output wire [3:0] cfg_req
);

   // Address match used to decode both the control and status words
   function addr_hit;
      input [9:0] addr;
      input [9:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   // Slot masks of the two builds and reset image of the control word;
   // the request registers take their reset value from this image so
   // the field positions live in one place only
   localparam [3:0] PRESENT_ALL = 4'hf;
   localparam [3:0] PRESENT_LOW = 4'h3;
   localparam [31:0] CTRL_RESET = `DGR_CTRL_RESET;

   // Picks one four-bit request field out of a bus word
   function [3:0] field4;
      input [31:0] word;
      input integer lsb;
      begin
         field4 = word[lsb +: 4];
      end
   endfunction

   // Places a four-bit field into an otherwise empty read word
   function [31:0] place4;
      input [3:0] bits;
      input integer lsb;
      begin
         place4 = 32'h00000000;
         place4[lsb +: 4] = bits;
      end
   endfunction

   // True when a slot's two mode bits select manual controlled mode
   function is_manual_ctl;
      input [1:0] mode;
      begin
         is_manual_ctl = (mode == `DGR_MODE_MANUAL_CTL);
      end
   endfunction

   // Request bits as software sees them; bit i is converter i+1
   reg [3:0] rst_req_reg;
   reg [3:0] pulse_req_reg;
   reg [3:0] rst_req_next;
   reg [3:0] pulse_req_next;
   // Per-slot qualifiers and sequencer handshakes
   wire [3:0] conv_present;
   wire [3:0] manual_ctl;
   wire [3:0] pulse_go;
   wire [3:0] rst_clear;
   wire [3:0] pulse_clear;
   wire [3:0] busy_flag;
   // Write decode and read images
   wire ctrl_wr;
   wire [3:0] rst_set;
   wire [3:0] pulse_set;
   wire [3:0] busy_seen;
   wire [31:0] ctrl_word;
   wire [31:0] stat_word;
   integer i;

   // Status word is read-only and has no clear-on-one bits, so a
   // write there is dropped; only the control word takes writes
   assign ctrl_wr = reg_wr && addr_hit(reg_addr, `DGR_CTRL_OFFSET); // RULE2 RULE10

   // Converters three and four vanish in the eight-channel build:
   // writes to their bits are dropped and they read back as zero
   assign conv_present = (NUM_CONV > 2) ? PRESENT_ALL : PRESENT_LOW; // RULE11

   // Only bits 19:16 and 3:0 are writable; the rest are dropped
   assign rst_set = field4(reg_wdata, `DGR_RESET_LSB) & conv_present & {4{ctrl_wr}}; // RULE3
   assign pulse_set = field4(reg_wdata, `DGR_PULSE_LSB) & conv_present & {4{ctrl_wr}};

   // A pending pulse reaches the sequencer only while its slot is in
   // manual controlled mode in that very cycle; a late mode change
   // must not let one slip out
   assign pulse_go = pulse_req_reg & manual_ctl; // RULE9

   // Busy reads high from the request edge on, one cycle before the
   // sequencer starts, so a status read straight after a request never
   // shows an idle converter
   assign busy_seen = (busy_flag | rst_req_reg | pulse_req_reg) & conv_present; // RULE12

   // Read images; reserved positions always read as zero
   assign ctrl_word = place4(rst_req_reg & conv_present, `DGR_RESET_LSB)
      | place4(pulse_req_reg & conv_present, `DGR_PULSE_LSB); // RULE3
   assign stat_word = place4(busy_seen, `DGR_BUSY_LSB); // RULE12

   // Request bits: writes only set, hardware clears; a set arriving
   // with its clear wins so no request is lost. The price is that a
   // reset written in its own clear cycle runs the reset once more.
   always @* begin
      rst_req_next = rst_req_reg;
      pulse_req_next = pulse_req_reg;
      for (i = 0; i < `DGR_NUM_CONV_MAX; i = i + 1) begin
         // Sequencer hands back a one-cycle clear once it is done
         if (rst_clear[i]) begin
            rst_req_next[i] = 1'b0; // RULE6
         end
         if (pulse_clear[i]) begin
            pulse_req_next[i] = 1'b0; // RULE7
         end
         // Software may only raise bits; zeros written are no-ops
         if (rst_set[i]) begin
            rst_req_next[i] = 1'b1; // RULE1 RULE4
         end
         if (pulse_set[i]) begin
            pulse_req_next[i] = 1'b1; // RULE1
         end
         // Sequencer or immediate mode: no pulse request is kept pending
         if (!manual_ctl[i]) begin
            pulse_req_next[i] = 1'b0; // RULE9
         end
      end
   end

   // Request registers; every request bit comes out of reset clear
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_req_reg <= CTRL_RESET[`DGR_RESET_LSB +: 4]; // RULE10
         pulse_req_reg <= CTRL_RESET[`DGR_PULSE_LSB +: 4];
      end else begin
         rst_req_reg <= rst_req_next;
         pulse_req_reg <= pulse_req_next;
      end
   end

   // Mode decode per converter; only manual controlled mode lets a
   // pulse request stand, the other codes drop it at once
   genvar g;
   generate
      for (g = 0; g < `DGR_NUM_CONV_MAX; g = g + 1) begin : g_mode
         assign manual_ctl[g] = is_manual_ctl(conv_mode[2*g +: 2]);
      end
   endgenerate

   // One sequencer per converter slot; absent slots never get requests
   // and their outside busy is masked, so they sit idle with the reset
   // pin released. All pins leave the sequencer straight from flops.
   generate
      for (g = 0; g < `DGR_NUM_CONV_MAX; g = g + 1) begin : g_chan
         dgr_conv_chan u_chan (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .rst_pending(rst_req_reg[g]),
            .pulse_pending(pulse_go[g]),
            .xfer_busy(xfer_busy[g] & conv_present[g]),
            .cfg_done(cfg_done[g]),
            .conv_reset_n(conv_reset_n[g]),
            .conv_pulse(conv_pulse[g]),
            .cfg_req(cfg_req[g]),
            .busy(busy_flag[g]),
            .rst_clear(rst_clear[g]),
            .pulse_clear(pulse_clear[g])
         );
      end
   endgenerate

   // Registered read port. Data is taken on the strobe edge and then
   // holds until the next read, so software may sample it late.
   // Unmapped offsets return zero so software never sees leftovers
   // of the request logic
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         if (addr_hit(reg_addr, `DGR_CTRL_OFFSET)) begin
            reg_rdata <= ctrl_word; // RULE1
         end else if (addr_hit(reg_addr, `DGR_STAT_OFFSET)) begin
            reg_rdata <= stat_word; // RULE12
         end else begin
            reg_rdata <= 32'h00000000; // RULE3
         end
      end
   end

endmodule
`default_nettype wire
